// file: core/ssl_pkg.sv
package ssl_pkg;

   // Unit states of a supervisor or monitor.
   typedef enum logic [1:0] {
      SSL_OFF    = 2'b00,
      SSL_NORMAL = 2'b01,
      SSL_FULL   = 2'b10
   } ssl_unit_e;

   // Power modes presented by the CPU side.
   typedef enum logic [2:0] {
      SSL_ACTIVE = 3'b000,
      SSL_DOZE0  = 3'b001,
      SSL_DOZE1  = 3'b010,
      SSL_SLEEP2 = 3'b011,
      SSL_SLEEP3 = 3'b100,
      SSL_SLEEP4 = 3'b101
   } ssl_pmode_e;

   // Register offsets.
   localparam logic [3:0] SSL_CORE_CTL_OFS   = 4'h0;
   localparam logic [3:0] SSL_SUPPLY_CTL_OFS = 4'h4;
   localparam logic [3:0] SSL_FLAG_OFS       = 4'h8;
   localparam logic [3:0] SSL_STATE_OFS      = 4'hC;

   // Side control register field positions.
   localparam int SSL_SUP_EN_BIT   = 0;
   localparam int SSL_SUP_KEEP_BIT = 1;
   localparam int SSL_SUP_FP_BIT   = 2;
   localparam int SSL_MON_EN_BIT   = 3;
   localparam int SSL_MON_FP_BIT   = 4;
   localparam int SSL_AUTO_BIT     = 5;
   localparam int SSL_CTL_W        = 6;

   // Flag register field positions.
   localparam int SSL_CORE_DLY_BIT   = 0;
   localparam int SSL_SUPPLY_DLY_BIT = 1;

   // Reset values: supervisor and monitor enabled, normal mode, manual control.
   localparam logic [5:0] SSL_CORE_CTL_RST   = 6'h0B;
   localparam logic [5:0] SSL_SUPPLY_CTL_RST = 6'h0B;

   // Timing at 200 MHz.
   localparam int SSL_CLK_MHZ      = 200;
   localparam int SSL_T_SLOW_US    = 150;
   localparam int SSL_T_FAST_US    = 2;
   localparam int SSL_T_OSC_US     = 6;
   localparam int SSL_SLOW_CYC     = SSL_T_SLOW_US * SSL_CLK_MHZ;
   localparam int SSL_FAST_CYC     = SSL_T_FAST_US * SSL_CLK_MHZ;
   localparam int SSL_OSC_CYC      = SSL_T_OSC_US * SSL_CLK_MHZ;
   localparam int SSL_CNT_W        = 16;

endpackage

// file: core/ssl_side_map.sv
`timescale 1ns/1ps
// Maps one side's control bits and the power mode to unit states.
module ssl_side_map (
   input  wire logic [5:0]         ctl,
   input  wire logic               low_power,
   output ssl_pkg::ssl_unit_e      sup_state,
   output ssl_pkg::ssl_unit_e      mon_state,
   output logic                    slow_wake
);
   logic sup_en;
   logic sup_keep;
   logic sup_fp;
   logic mon_en;
   logic mon_fp;
   logic auto_ctl;

   assign sup_en   = ctl[ssl_pkg::SSL_SUP_EN_BIT];
   assign sup_keep = ctl[ssl_pkg::SSL_SUP_KEEP_BIT];
   assign sup_fp   = ctl[ssl_pkg::SSL_SUP_FP_BIT];
   assign mon_en   = ctl[ssl_pkg::SSL_MON_EN_BIT];
   assign mon_fp   = ctl[ssl_pkg::SSL_MON_FP_BIT];
   assign auto_ctl = ctl[ssl_pkg::SSL_AUTO_BIT];

   // Table mapping; a disabled unit is off everywhere.
   always_comb begin
      sup_state = ssl_pkg::SSL_OFF;
      mon_state = ssl_pkg::SSL_OFF;
      if (sup_en) begin // (RQ18)
         if (!low_power) begin
            sup_state = sup_fp ? ssl_pkg::SSL_FULL : ssl_pkg::SSL_NORMAL;
         end else if (auto_ctl) begin
            sup_state = (sup_keep && sup_fp) ? ssl_pkg::SSL_NORMAL : ssl_pkg::SSL_OFF; // (RQ11)
         end else if (sup_keep) begin
            sup_state = sup_fp ? ssl_pkg::SSL_FULL : ssl_pkg::SSL_NORMAL; // (RQ10)
         end
      end
      if (mon_en) begin // (RQ18)
         if (!low_power || !auto_ctl) begin
            mon_state = mon_fp ? ssl_pkg::SSL_FULL : ssl_pkg::SSL_NORMAL; // (RQ10)
         end else begin
            // Automatic mode keeps only a full-performance monitor alive.
            mon_state = mon_fp ? ssl_pkg::SSL_NORMAL : ssl_pkg::SSL_OFF; // (RQ11)
         end
      end
   end

   // Slow wake whenever either unit is enabled in normal mode.
   assign slow_wake = (sup_en && !sup_fp) || (mon_en && !mon_fp); // (RQ12)
endmodule

// file: core/ssl_top.sv
`timescale 1ns/1ps
// Contract
// (RQ1) Normal-mode core units hold CPU execution 150 us after sleep three/four wake.
// (RQ2) Core units off or full performance: hold-off lasts only 2 us.
// (RQ3) Oscillator runs fast 6 us after wake; subsystem clock is not gated.
// (RQ4) Firmware sets main divider to divide-by-two before deep sleep.
// (RQ5) Firmware waits 32/48/80/100 cycles before restoring full main clock.
// (RQ6) Full-performance core supervisor settles in about 2 us.
// (RQ7) Normal-mode core supervisor settles in about 150 us.
// (RQ8) Firmware clears core full-performance bit before raising core voltage.
// (RQ9) Firmware waits both delay flags low before entering sleep two to four.
// (RQ10) Manual core control: supervisor kept only if keep bit set; monitor kept.
// (RQ11) Automatic core control: full drops to normal, normal or disabled off; the supervisor drops to normal only with its keep bit set, else off.
// (RQ12) Wake is slow when core unit enabled normal, fast otherwise.
// (RQ13) Supply side uses the same manual and automatic mapping; the code forces its automatic-mode monitor off in sleep.
// (RQ14) Firmware adds 150 us delay when fast wake needs fast servicing.
// (RQ15) Firmware keeps subsystem clock request enabled, halts its modules first.
// (RQ16) Automatic supply control: supply monitor inactive in sleep two to four.
// (RQ17) Write to a side register sets its delay flag until settled.
// (RQ18) A disabled unit stays off in every mode.
module ssl_top #(
   parameter int SLOW_CYC = ssl_pkg::SSL_SLOW_CYC,
   parameter int FAST_CYC = ssl_pkg::SSL_FAST_CYC,
   parameter int OSC_CYC  = ssl_pkg::SSL_OSC_CYC
) (
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   input  wire logic               ce,
   input  wire logic [3:0]         addr,
   input  wire logic [31:0]        wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output logic [31:0]             rdata,
   input  wire logic [2:0]         pmode,
   output logic [1:0]              core_supervisor,
   output logic [1:0]              core_monitor,
   output logic [1:0]              supply_supervisor,
   output logic [1:0]              supply_monitor,
   output logic                    cpu_hold,
   output logic                    osc_fast,
   output logic                    core_side_delay_flag,
   output logic                    supply_side_delay_flag
);
   typedef enum logic [1:0] {
      WK_IDLE  = 2'b00,
      WK_HOLD  = 2'b01
   } ssl_wake_e;

   logic [5:0]                 core_side_ctl_reg_r;
   logic [5:0]                 supply_side_ctl_reg_r;
   logic                       lp_r;
   logic                       deep_r;
   logic                       low_power;
   logic                       deep;
   logic [ssl_pkg::SSL_CNT_W-1:0] core_dly_cnt_r;
   logic [ssl_pkg::SSL_CNT_W-1:0] supply_dly_cnt_r;
   logic [ssl_pkg::SSL_CNT_W-1:0] hold_cnt_r;
   logic [ssl_pkg::SSL_CNT_W-1:0] osc_cnt_r;
   ssl_wake_e                  wk_r;
   ssl_pkg::ssl_unit_e         c_sup;
   ssl_pkg::ssl_unit_e         c_mon;
   ssl_pkg::ssl_unit_e         s_sup;
   ssl_pkg::ssl_unit_e         s_mon;
   logic                       core_slow;
   logic                       wr_core;
   logic                       wr_supply;

   assign low_power = (pmode == ssl_pkg::SSL_SLEEP2) || (pmode == ssl_pkg::SSL_SLEEP3)
                      || (pmode == ssl_pkg::SSL_SLEEP4);
   assign deep      = (pmode == ssl_pkg::SSL_SLEEP3) || (pmode == ssl_pkg::SSL_SLEEP4);
   assign wr_core   = wr && (addr == ssl_pkg::SSL_CORE_CTL_OFS);
   assign wr_supply = wr && (addr == ssl_pkg::SSL_SUPPLY_CTL_OFS);

   // Core side mapping.
   ssl_side_map u_core (
      .ctl       (core_side_ctl_reg_r),
      .low_power (low_power),
      .sup_state (c_sup),
      .mon_state (c_mon),
      .slow_wake (core_slow)
   );

   // Supply side mapping; the monitor in automatic mode is off in sleep. (RQ13)
   ssl_side_map u_supply (
      .ctl       (supply_side_ctl_reg_r),
      .low_power (low_power),
      .sup_state (s_sup),
      .mon_state (s_mon),
      .slow_wake ()
   );

   // Control registers written by software.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         core_side_ctl_reg_r   <= ssl_pkg::SSL_CORE_CTL_RST;
         supply_side_ctl_reg_r <= ssl_pkg::SSL_SUPPLY_CTL_RST;
      end else if (ce) begin
         if (wr_core) begin
            core_side_ctl_reg_r <= wdata[ssl_pkg::SSL_CTL_W-1:0];
         end
         if (wr_supply) begin
            supply_side_ctl_reg_r <= wdata[ssl_pkg::SSL_CTL_W-1:0];
         end
      end
   end

   // Unit state outputs, registered.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         core_supervisor   <= ssl_pkg::SSL_OFF;
         core_monitor      <= ssl_pkg::SSL_OFF;
         supply_supervisor <= ssl_pkg::SSL_OFF;
         supply_monitor    <= ssl_pkg::SSL_OFF;
      end else if (ce) begin
         core_supervisor   <= c_sup;
         core_monitor      <= c_mon;
         supply_supervisor <= s_sup; // (RQ13)
         // Automatic supply control never leaves the monitor running in sleep.
         supply_monitor    <= (low_power && supply_side_ctl_reg_r[ssl_pkg::SSL_AUTO_BIT])
                              ? ssl_pkg::SSL_OFF : s_mon; // (RQ16)
      end
   end

   // Settling delay per side: a write restarts the count; normal mode is slow.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         core_dly_cnt_r   <= '0;
         supply_dly_cnt_r <= '0;
      end else if (ce) begin
         if (wr_core) begin // (RQ17)
            core_dly_cnt_r <= wdata[ssl_pkg::SSL_SUP_FP_BIT]
                              ? ssl_pkg::SSL_CNT_W'(FAST_CYC)   // (RQ6)
                              : ssl_pkg::SSL_CNT_W'(SLOW_CYC);  // (RQ7)
         end else if (core_dly_cnt_r != '0) begin
            core_dly_cnt_r <= core_dly_cnt_r - 1'b1;
         end
         if (wr_supply) begin // (RQ17)
            supply_dly_cnt_r <= wdata[ssl_pkg::SSL_SUP_FP_BIT]
                                ? ssl_pkg::SSL_CNT_W'(FAST_CYC)
                                : ssl_pkg::SSL_CNT_W'(SLOW_CYC);
         end else if (supply_dly_cnt_r != '0) begin
            supply_dly_cnt_r <= supply_dly_cnt_r - 1'b1;
         end
      end
   end

   // Flags follow the counters; a write sets in the same edge it lands.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         core_side_delay_flag   <= 1'b0;
         supply_side_delay_flag <= 1'b0;
      end else if (ce) begin
         core_side_delay_flag   <= wr_core || (core_dly_cnt_r > 1); // (RQ17)
         supply_side_delay_flag <= wr_supply || (supply_dly_cnt_r > 1); // (RQ17)
      end
   end

   // Wake hold-off: leaving sleep three/four masks execution, length by core setup.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lp_r       <= 1'b0;
         deep_r     <= 1'b0;
         wk_r       <= WK_IDLE;
         hold_cnt_r <= '0;
         osc_cnt_r  <= '0;
         cpu_hold   <= 1'b0;
         osc_fast   <= 1'b0;
      end else if (ce) begin
         lp_r   <= low_power;
         deep_r <= deep;
         // Oscillator overshoot window; subsystem clock stays ungated meanwhile.
         if (deep_r && !deep) begin
            osc_cnt_r <= ssl_pkg::SSL_CNT_W'(OSC_CYC); // (RQ3)
            osc_fast  <= 1'b1;
         end else if (osc_cnt_r > 1) begin
            osc_cnt_r <= osc_cnt_r - 1'b1;
         end else begin
            osc_cnt_r <= '0;
            osc_fast  <= 1'b0;
         end
         case (wk_r)
            WK_IDLE: begin
               if (deep_r && !deep) begin
                  wk_r       <= WK_HOLD;
                  cpu_hold   <= 1'b1;
                  hold_cnt_r <= core_slow ? ssl_pkg::SSL_CNT_W'(SLOW_CYC)  // (RQ1)
                                          : ssl_pkg::SSL_CNT_W'(FAST_CYC); // (RQ2)
               end
            end
            WK_HOLD: begin
               if (deep_r && !deep) begin
                  // A wake during a running hold restarts it, so no wake goes unmasked.
                  hold_cnt_r <= core_slow ? ssl_pkg::SSL_CNT_W'(SLOW_CYC)  // (RQ1)
                                          : ssl_pkg::SSL_CNT_W'(FAST_CYC); // (RQ2)
               end else if (hold_cnt_r > 1) begin
                  hold_cnt_r <= hold_cnt_r - 1'b1;
               end else begin
                  hold_cnt_r <= '0;
                  cpu_hold   <= 1'b0;
                  wk_r       <= WK_IDLE;
               end
            end
            default: begin
               wk_r     <= WK_IDLE;
               cpu_hold <= 1'b0;
            end
         endcase
      end
   end

   // Read port: data stand in the cycle after the strobe; unmapped reads zero.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd) begin
            case (addr)
               ssl_pkg::SSL_CORE_CTL_OFS:   rdata <= {26'h0, core_side_ctl_reg_r};
               ssl_pkg::SSL_SUPPLY_CTL_OFS: rdata <= {26'h0, supply_side_ctl_reg_r};
               ssl_pkg::SSL_FLAG_OFS: begin
                  rdata <= {30'h0, supply_side_delay_flag, core_side_delay_flag};
               end
               ssl_pkg::SSL_STATE_OFS: begin
                  rdata <= {20'h0, osc_fast, cpu_hold, lp_r, 1'b0, supply_monitor,
                            supply_supervisor, core_monitor, core_supervisor};
               end
               default: rdata <= '0;
            endcase
         end
      end
   end
endmodule

// file: tb/ssl_top_sva.sv
`timescale 1ns/1ps
// Port-level checks of ssl_top; counts follow the parameters handed down by the bind.
module ssl_chk #(
   parameter int SLOW_CYC = 40,
   parameter int FAST_CYC = 4,
   parameter int OSC_CYC  = 12
) (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic [3:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic [2:0]  pmode,
   input wire logic [1:0]  core_supervisor,
   input wire logic        cpu_hold,
   input wire logic        osc_fast,
   input wire logic        core_side_delay_flag,
   input wire logic        supply_side_delay_flag
);
   int hold_run;
   int osc_run;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // Window lengths are counted here, since full-size counts are far too long to unroll.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hold_run <= 0;
         osc_run  <= 0;
      end else if (ce) begin
         hold_run <= cpu_hold ? hold_run + 1 : 0;
         osc_run  <= osc_fast ? osc_run + 1 : 0;
      end
   end

   // A state output lags its control write by two edges, so ce must hold over both.
   property p_off_dis;
      (ce && wr && addr == 4'h0 && !wdata[0]) ##1 ce |=> core_supervisor == 2'h0;
   endproperty
   property p_fp_act;
      (ce && wr && addr == 4'h0 && wdata[2:0] == 3'h5 && pmode == 3'h0) ##1
         (ce && pmode == 3'h0) |=> core_supervisor == 2'h2;
   endproperty
   property p_core_flag;
      ce && wr && addr == 4'h0 |=> core_side_delay_flag;
   endproperty
   property p_sup_flag;
      ce && wr && addr == 4'h4 |=> supply_side_delay_flag;
   endproperty
   property p_hold_min;
      $fell(cpu_hold) |-> hold_run >= FAST_CYC;
   endproperty
   property p_wake;
      ce && ($past(pmode) == 3'h4 || $past(pmode) == 3'h5) && pmode < 3'h4
         |-> ##[1:2] (cpu_hold && osc_fast);
   endproperty
   property p_osc_len;
      $fell(osc_fast) |-> osc_run == OSC_CYC;
   endproperty
   property p_rd_idle;
      !(ce && rd) |=> rdata == 32'h0;
   endproperty

   a_off_dis:   assert property (p_off_dis) else $error("disabled supervisor not off");
   a_fp_act:    assert property (p_fp_act) else $error("supervisor not full");
   a_core_flag: assert property (p_core_flag) else $error("core delay flag not set");
   a_sup_flag:  assert property (p_sup_flag) else $error("supply delay flag not set");
   a_hold_min:  assert property (p_hold_min) else $error("hold too short");
   a_wake:      assert property (p_wake) else $error("no hold after wake");
   a_osc_len:   assert property (p_osc_len) else $error("overshoot window wrong");
   a_rd_idle:   assert property (p_rd_idle) else $error("read data not zero");

   c_wake: cover property ($rose(cpu_hold));
   c_flag: cover property ($fell(core_side_delay_flag));
   c_rd:   cover property (rd && ce);
endmodule

bind ssl_top ssl_chk #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC), .OSC_CYC(OSC_CYC)) u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .pmode(pmode), .core_supervisor(core_supervisor), .cpu_hold(cpu_hold),
   .osc_fast(osc_fast), .core_side_delay_flag(core_side_delay_flag),
   .supply_side_delay_flag(supply_side_delay_flag));

// file: tb/ssl_top_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: register access, unit state mapping, settling and wake timing.
module ssl_top_tb_top;
   localparam int SLOW = 40;
   localparam int FAST = 4;
   localparam int OSC  = 12;
   logic              clk_sys = 1'b0;
   logic              rstn    = 1'b0;
   logic              ce      = 1'b1;
   logic [3:0]        addr    = 4'h0;
   logic [31:0]       wdata   = 32'h0;
   logic              wr      = 1'b0;
   logic              rd      = 1'b0;
   logic [2:0]        pmode   = 3'h0;
   logic [31:0]       rdata;
   logic [1:0]        csup, cmon, ssup, smon;
   logic              cpu_hold, osc_fast, cflag, sflag;
   logic [3:0]        ec, es;
   logic [31:0]       lf = 32'h6CF8;
   logic [31:0]       g;
   int                n_mismatch = 0;
   int                n_tests = 0;
   int                h, o, c, s;

   ssl_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .OSC_CYC(OSC)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pmode(pmode), .core_supervisor(csup), .core_monitor(cmon),
      .supply_supervisor(ssup), .supply_monitor(smon), .cpu_hold(cpu_hold),
      .osc_fast(osc_fast), .core_side_delay_flag(cflag), .supply_side_delay_flag(sflag));

   initial forever #2.5 clk_sys = ~clk_sys;

   // Expected {monitor, supervisor} states; in automatic sleep a supervisor needs keep and full to stay on, a monitor only full.
   // The supply monitor is off outright in automatic sleep, whatever its full bit says.
   function automatic logic [3:0] st(input logic [5:0] v, input logic lp, input logic hs);
      logic [1:0] su, mo;
      su = !v[0] ? 2'h0 : (v[2] ? 2'h2 : 2'h1);
      mo = !v[3] ? 2'h0 : (v[4] ? 2'h2 : 2'h1);
      if (lp && v[5]) begin
         su = (v[1] && su == 2'h2) ? 2'h1 : 2'h0;
         mo = (mo == 2'h2 && !hs) ? 2'h1 : 2'h0;
      end else if (lp && !v[1]) begin
         su = 2'h0;
      end
      return {mo, su};
   endfunction

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_tests++;
      if (v !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, v);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Firmware side: never enter sleep while either side is still settling.
   task automatic settle;
      repeat (2) @(posedge clk_sys);
      for (int k = 0; k < 200; k++) begin
         #1;
         if (cflag === 1'b0 && sflag === 1'b0) break;
         @(posedge clk_sys);
      end
      @(posedge clk_sys);
   endtask

   task automatic measure;
      h = 0; o = 0; c = 0; s = 0;
      repeat (60) begin
         @(posedge clk_sys);
         #1;
         h += int'(cpu_hold); o += int'(osc_fast); c += int'(cflag); s += int'(sflag);
      end
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_reg(4'h0, g); chk("core_ctl", 32'h0B, g);
      rd_reg(4'h8, g); chk("flags", 32'h0, g);
      rd_reg(4'h2, g); chk("unmapped", 32'h0, g);
      // A write while ce is low must leave both the register and the flag alone.
      @(posedge clk_sys);
      ce <= 1'b0;
      wr_reg(4'h0, 32'h0);
      ce <= 1'b1;
      rd_reg(4'h0, g); chk("core_ctl_ce", 32'h0B, g);
      chk("core_flag_ce", 32'h0, {31'h0, cflag});
      // Settling time follows the written full-performance bit, per side.
      for (int sd = 0; sd < 2; sd++) begin
         for (int fp = 0; fp < 2; fp++) begin
            wr_reg(sd ? 4'h4 : 4'h0, fp ? 32'h07 : 32'h0B);
            measure();
            chk("dly_len", 32'h1, 32'((sd ? s : c) >= (fp ? FAST : SLOW) - 1 &&
                (sd ? s : c) <= (fp ? FAST : SLOW) + 1));
            chk("other_dly", 32'h0, 32'(sd ? c : s));
         end
      end
      // Every core setting against a random supply setting, awake and asleep.
      for (int i = 0; i < 64; i++) begin
         lf = lfsr(lf);
         wr_reg(4'h0, 32'(i));
         wr_reg(4'h4, lf);
         rd_reg(4'h4, g); chk("supply_ctl", {26'h0, lf[5:0]}, g);
         settle();
         for (int lp = 0; lp < 2; lp++) begin
            @(posedge clk_sys);
            pmode <= 3'(lp * 3 + int'(lf[7:6]) % 3);
            repeat (3) @(posedge clk_sys);
            ec = st(6'(i), 1'(lp), 1'b0);
            es = st(lf[5:0], 1'(lp), 1'b1);
            #1 chk("core_units", {28'h0, ec}, {28'h0, cmon, csup});
            chk("supply_units", {28'h0, es}, {28'h0, smon, ssup});
            rd_reg(4'hC, g); chk("state_reg", {24'h0, es, ec}, g & 32'hFF);
         end
      end
      // Wake from both deep sleep levels: slow, full-performance and disabled units.
      for (int k = 0; k < 6; k++) begin
         wr_reg(4'h0, k % 3 == 0 ? 32'h0B : (k % 3 == 1 ? 32'h1D : 32'h00));
         settle();
         // Divider halving and the clock request live outside this block; firmware keeps them.
         pmode <= k < 3 ? 3'h4 : 3'h5;
         repeat (4) @(posedge clk_sys);
         pmode <= 3'h0;
         measure();
         chk("hold_len", k % 3 == 0 ? SLOW : FAST, h);
         chk("osc_len", OSC, o);
      end
      stop_test();
   end

   // Cuts a hang short; the full sequence needs well under this many cycles.
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_mismatch++;
      stop_test();
   end
endmodule
